/* File: hdl/bts_cfg.svh */
/*
 Timing counts, reset values and register offsets for the beam teach sequencer.
 Assumes inclusion by bare name from the package and the design file.
*/
`ifndef BTS_CFG_SVH
`define BTS_CFG_SVH
`define BTS_CLK_HZ 40000000
`define BTS_PULSE_MIN_MS 20
`define BTS_PULSE_MAX_MS 80
`define BTS_PULSE_MIN_CYC ((`BTS_CLK_HZ / 1000) * `BTS_PULSE_MIN_MS + 1)
`define BTS_PULSE_MAX_CYC ((`BTS_CLK_HZ / 1000) * `BTS_PULSE_MAX_MS)
`define BTS_OFF_CTRL 12'h000
`define BTS_OFF_CMD 12'h004
`define BTS_OFF_STAT 12'h008
`define BTS_OFF_COUNT 12'h00c
`define BTS_OFF_BLANK 12'h010
`define BTS_OFF_DEACT 12'h014
`define BTS_CTRL_MODE 0
`define BTS_CTRL_NONVOL 1
`define BTS_CTRL_PWRUP 2
`define BTS_CTRL_SINK 3
`define BTS_CTRL_MARGIN 4
`define BTS_CTRL_RESET 32'h0000_0002
`define BTS_LEVEL_FULL 8'hff
`define BTS_LEVEL_MIN 8'h80
`endif

/* File: hdl/bts_pkg.sv */
/*
 Types shared by the beam teach sequencer.
 Assumes bts_cfg.svh is on the include path.
*/
`include "bts_cfg.svh"
package bts_pkg;
   typedef enum logic [1:0] {
      BTS_IDLE = 2'b00,
      BTS_RUN = 2'b01,
      BTS_DONE = 2'b10
   } bts_state_t;
   typedef struct packed {
      logic mode_align;
      logic nonvol;
      logic pwrup_teach;
      logic sink_logic;
      logic [3:0] margin;
   } bts_ctrl_t;
   typedef struct packed {
      logic waiting;
      logic align_view;
      logic [7:0] first_beam_level;
      logic [7:0] last_beam_level;
   } bts_disp_t;
endpackage

/* File: hdl/bts_sequencer.sv */
/*
 Beam teach sequencer: mode select, display content, teach control and the timed teach input.
 Assumes beam levels arrive synchronous to clk, while the teach line is an asynchronous pin.
*/
// The register offsets and the APB register port were decided locally.
//
// Contract
// R01: Start in process mode after reset; software switches process and alignment mode.
// R02: Alignment view shows first and last beam levels as two bars.
// R03: A teach proceeds only when signal level reaches the middle bar mark.
// R04: Process view shows interrupted beam count and the configurable IO states.
// R05: Teach checks every beam lies in corridor and regulates to function reserve; the code checks only beams that are not blocked.
// R06: Without blanking areas any interrupted beam during teach flags an error.
// R07: With blanking areas, permanently interrupted beams are marked deactivated.
// R08: A setting keeps teach results non-volatile or volatile; default non-volatile.
// R09: Teach requests are accepted in process mode and in alignment mode.
// R10: Blanking teach widens interrupted regions by a margin of neighbour beams.
// R11: At most four blanking regions are supported.
// R12: Waiting shown during teach; on success the start mode view returns.
// R13: Success shows both bars full; failure shows both bars empty.
// R14: Power-up teach option runs one teach automatically after reset.
// R15: Teach starts on a line pulse longer than 20 ms, shorter than 80 ms.
// R16: Teach line polarity follows sourcing or sinking switching logic.
// R17: Operator should teach again after changing the beam scanning mode.
// R18: Pulses too short or reaching maximum width are ignored.
`timescale 1ns/1ps
`include "bts_cfg.svh"
module bts_sequencer import bts_pkg::*; #(
   parameter int BEAMS = 32,
   parameter int PULSE_MIN_CYC = `BTS_PULSE_MIN_CYC,
   parameter int PULSE_MAX_CYC = `BTS_PULSE_MAX_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic config_io_line_one,
   input wire logic config_io_line_two,
   input wire logic [BEAMS-1:0] beam_blocked,
   input wire logic [BEAMS-1:0] beam_in_corridor,
   input wire logic [7:0] first_beam_raw,
   input wire logic [7:0] last_beam_raw,
   output logic reserve_adjust,
   output logic nv_store,
   output bts_disp_t disp,
   output logic [7:0] interrupted_beam_count,
   output logic [1:0] io_state,
   output logic [BEAMS-1:0] beam_deact
);
   bts_ctrl_t ctrl;
   bts_state_t state;
   logic [2:0] blank_areas;
   logic io_meta;
   logic io_sync;
   logic io2_meta;
   logic io2_sync;
   logic level_low;
   logic blocked_bad;
   logic corridor_bad;
   logic io_active;
   logic [31:0] pulse_cnt;
   logic pulse_fire;
   logic cmd_teach;
   logic pwrup_pending;
   logic teach_req;
   logic teach_fail;
   logic teach_ok;
   logic last_ok;
   logic have_result;
   logic wr;
   logic [BEAMS-1:0] widened;
   logic [7:0] count;

   // Fields are picked by name, so the packed member order cannot skew the reset word.
   localparam logic [31:0] CTRL_RST = `BTS_CTRL_RESET;

   assign wr = psel && penable && pwrite;
   assign pready = 1'b1;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= '{mode_align: CTRL_RST[`BTS_CTRL_MODE], // see R01
            nonvol: CTRL_RST[`BTS_CTRL_NONVOL], // see R08
            pwrup_teach: CTRL_RST[`BTS_CTRL_PWRUP],
            sink_logic: CTRL_RST[`BTS_CTRL_SINK],
            margin: CTRL_RST[`BTS_CTRL_MARGIN+3:`BTS_CTRL_MARGIN]};
         blank_areas <= 3'h0;
      end else if (wr && paddr == `BTS_OFF_CTRL) begin
         ctrl.mode_align <= pwdata[`BTS_CTRL_MODE]; // see R01
         ctrl.nonvol <= pwdata[`BTS_CTRL_NONVOL]; // see R08
         ctrl.pwrup_teach <= pwdata[`BTS_CTRL_PWRUP];
         ctrl.sink_logic <= pwdata[`BTS_CTRL_SINK];
         ctrl.margin <= pwdata[`BTS_CTRL_MARGIN+3:`BTS_CTRL_MARGIN];
      end else if (wr && paddr == `BTS_OFF_BLANK) begin
         // Requests above four areas are clipped rather than refused. see R11
         blank_areas <= (pwdata[2:0] > 3'h4) ? 3'h4 : pwdata[2:0];
      end
   end

   assign cmd_teach = wr && paddr == `BTS_OFF_CMD && pwdata[0]; // see R09

   always_comb begin
      pslverr = 1'b0;
      if (psel && penable && !(paddr == `BTS_OFF_CTRL || paddr == `BTS_OFF_CMD || paddr == `BTS_OFF_STAT
            || paddr == `BTS_OFF_COUNT || paddr == `BTS_OFF_BLANK || paddr == `BTS_OFF_DEACT)) begin
         pslverr = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         if (paddr == `BTS_OFF_CTRL) begin
            prdata <= {24'h0, ctrl.margin, ctrl.sink_logic, ctrl.pwrup_teach, ctrl.nonvol, ctrl.mode_align};
         end else if (paddr == `BTS_OFF_STAT) begin
            prdata <= {28'h0, have_result, last_ok, state};
         end else if (paddr == `BTS_OFF_COUNT) begin
            prdata <= {24'h0, interrupted_beam_count};
         end else if (paddr == `BTS_OFF_BLANK) begin
            prdata <= {29'h0, blank_areas};
         end else if (paddr == `BTS_OFF_DEACT) begin
            prdata <= 32'(beam_deact);
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // The line is asynchronous, so it passes two flops before any decision.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         io_meta <= 1'b0;
         io_sync <= 1'b0;
         io2_meta <= 1'b0;
         io2_sync <= 1'b0;
      end else begin
         io_meta <= config_io_line_one;
         io_sync <= io_meta;
         io2_meta <= config_io_line_two;
         io2_sync <= io2_meta;
      end
   end

   assign io_active = io_sync ^ ctrl.sink_logic; // see R16

   // A pulse fires on its falling edge only; holding to the maximum kills it. see R15 see R18
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pulse_cnt <= 32'h0;
         pulse_fire <= 1'b0;
      end else begin
         pulse_fire <= 1'b0;
         if (io_active) begin
            if (pulse_cnt < 32'(PULSE_MAX_CYC)) begin
               pulse_cnt <= pulse_cnt + 32'h1;
            end
         end else begin
            if (pulse_cnt >= 32'(PULSE_MIN_CYC) && pulse_cnt < 32'(PULSE_MAX_CYC)) begin
               pulse_fire <= 1'b1; // see R15
            end
            pulse_cnt <= 32'h0;
         end
      end
   end

   // The option stays armed until the first teach runs, so a restored setting still fires once. see R14
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pwrup_pending <= 1'b1;
      end else if (state == BTS_RUN) begin
         pwrup_pending <= 1'b0;
      end
   end

   assign teach_req = cmd_teach || pulse_fire || (pwrup_pending && ctrl.pwrup_teach); // see R09 see R14

   // Blanked beams are widened by the margin on both sides. see R10
   always_comb begin
      widened = '0;
      for (int i = 0; i < BEAMS; i++) begin
         for (int d = -15; d <= 15; d++) begin
            if ((d <= $signed({1'b0, ctrl.margin})) && (-d <= $signed({1'b0, ctrl.margin}))
                  && i + d >= 0 && i + d < BEAMS) begin
               if (beam_blocked[i + d]) begin
                  widened[i] = 1'b1;
               end
            end
         end
      end
   end

   // Low level or, without blanking, any interrupted beam fails the teach. see R03 see R06
   assign level_low = (first_beam_raw < `BTS_LEVEL_MIN) || (last_beam_raw < `BTS_LEVEL_MIN); // see R03
   assign blocked_bad = blank_areas == 3'h0 && |beam_blocked; // see R06
   // A blocked beam cannot be judged against the corridor, so only free beams are checked.
   assign corridor_bad = |(~beam_in_corridor & ~beam_blocked); // see R05
   assign teach_fail = level_low || blocked_bad || corridor_bad;
   assign teach_ok = !teach_fail;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= BTS_IDLE;
      end else begin
         case (state)
            BTS_IDLE: begin
               if (teach_req) begin
                  state <= BTS_RUN;
               end
            end
            BTS_RUN: begin
               state <= BTS_DONE;
            end
            default: begin
               state <= BTS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last_ok <= 1'b0;
         have_result <= 1'b0;
         beam_deact <= '0;
         reserve_adjust <= 1'b0;
         nv_store <= 1'b0;
      end else begin
         reserve_adjust <= 1'b0;
         nv_store <= 1'b0;
         if (state == BTS_RUN) begin
            last_ok <= teach_ok; // see R13
            have_result <= 1'b1;
            if (teach_ok) begin
               reserve_adjust <= 1'b1; // see R05
               nv_store <= ctrl.nonvol; // see R08
               beam_deact <= (blank_areas != 3'h0) ? widened : '0; // see R07 see R10
            end
         end else if (state == BTS_IDLE && teach_req) begin
            have_result <= 1'b0;
         end
      end
   end

   always_comb begin
      count = 8'h0;
      for (int i = 0; i < BEAMS; i++) begin
         count = count + {7'h0, beam_blocked[i] & ~beam_deact[i]};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         interrupted_beam_count <= 8'h0;
         io_state <= 2'b00;
         disp <= '0;
      end else begin
         interrupted_beam_count <= count; // see R04
         io_state <= {io2_sync, io_sync}; // see R04
         disp.waiting <= state != BTS_IDLE; // see R12
         disp.align_view <= ctrl.mode_align; // see R12
         if (have_result) begin
            disp.first_beam_level <= last_ok ? `BTS_LEVEL_FULL : 8'h00; // see R13
            disp.last_beam_level <= last_ok ? `BTS_LEVEL_FULL : 8'h00;
         end else begin
            disp.first_beam_level <= first_beam_raw; // see R02
            disp.last_beam_level <= last_beam_raw;
         end
      end
   end

   // Display and sequencing checks.
   teach_waits_a: assert property (@(posedge clk) disable iff (!rst_n)
      state == BTS_RUN |-> ##1 state == BTS_DONE ##1 disp.waiting) else $error("waiting missing"); // see R12

   waiting_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      state == BTS_IDLE |=> !disp.waiting) else $error("waiting stuck"); // see R12

   mode_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(rst_n) |-> !ctrl.mode_align) else $error("not process mode"); // see R01

   // An inactive line must clear the width counter, whichever switching logic is chosen.
   polarity_a: assert property (@(posedge clk) disable iff (!rst_n)
      !io_active |=> pulse_cnt == 32'h0) else $error("polarity wrong"); // see R16

   short_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
      pulse_fire |-> $past(pulse_cnt) >= 32'(PULSE_MIN_CYC)) else $error("short pulse fired"); // see R18

   long_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
      pulse_fire |-> $past(pulse_cnt) < 32'(PULSE_MAX_CYC)) else $error("long pulse fired"); // see R15

   idle_accept_a: assert property (@(posedge clk) disable iff (!rst_n)
      state == BTS_IDLE && teach_req |=> state == BTS_RUN) else $error("request lost"); // see R09

   pwrup_run_a: assert property (@(posedge clk) disable iff (!rst_n)
      state == BTS_IDLE && pwrup_pending && ctrl.pwrup_teach |=> state == BTS_RUN) else $error("no power-up teach"); // see R14

   // Result checks.
   fail_bars_a: assert property (@(posedge clk) disable iff (!rst_n)
      have_result && !last_ok |=> disp.first_beam_level == 8'h00) else $error("bars not empty"); // see R13

   ok_bars_a: assert property (@(posedge clk) disable iff (!rst_n)
      have_result && last_ok |=> disp.last_beam_level == `BTS_LEVEL_FULL) else $error("bars not full"); // see R13

   raw_bars_a: assert property (@(posedge clk) disable iff (!rst_n)
      !have_result |=> disp.first_beam_level == $past(first_beam_raw)) else $error("bar not live"); // see R02

   low_level_a: assert property (@(posedge clk) disable iff (!rst_n)
      state == BTS_RUN && first_beam_raw < `BTS_LEVEL_MIN |=> !last_ok) else $error("low level taught"); // see R03

   no_blank_a: assert property (@(posedge clk) disable iff (!rst_n)
      state == BTS_RUN && blank_areas == 3'h0 && |beam_blocked |=> !reserve_adjust) else $error("blocked ok"); // see R06

   adjust_src_a: assert property (@(posedge clk) disable iff (!rst_n)
      reserve_adjust |-> $past(state) == BTS_RUN) else $error("stray adjust"); // see R05

   deact_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      state == BTS_RUN && teach_ok && blank_areas == 3'h0 |=> beam_deact == '0) else $error("deact kept"); // see R07

   widen_cover_a: assert property (@(posedge clk) disable iff (!rst_n)
      state == BTS_RUN && teach_ok && blank_areas != 3'h0 |=> (beam_deact & $past(beam_blocked)) == $past(beam_blocked))
      else $error("blocked beam active"); // see R10

   blank_limit_a: assert property (@(posedge clk) disable iff (!rst_n)
      blank_areas <= 3'h4) else $error("too many areas"); // see R11

   store_a: assert property (@(posedge clk) disable iff (!rst_n)
      nv_store |-> reserve_adjust && ctrl.nonvol) else $error("bad store"); // see R08

   count_a: assert property (@(posedge clk) disable iff (!rst_n)
      $past(rst_n) |-> interrupted_beam_count == $past(count)) else $error("count wrong"); // see R04
endmodule

/* File: bench/bts_teach_ctl.sv */
/*
 Model of the external controller that drives the teach line with timed pulses.
 Assumes a request strobe and a width in clk cycles from the bench.
*/
`timescale 1ns/1ps
module bts_teach_ctl (
   input wire logic clk,
   input wire logic sink,
   input wire logic go,
   input wire logic [15:0] width,
   output logic line,
   output logic busy
);
   logic [15:0] left = '0;
   always_ff @(posedge clk) begin
      if (go && left == 0) begin
         left <= width;
      end else if (left != 0) begin
         left <= left - 1;
      end
   end
   // The idle level is the inactive one, so a polarity change alone never reads as a pulse.
   assign line = (left != 0) ? ~sink : sink;
   assign busy = left != 0;
endmodule

/* File: bench/beam_teach_sequencer_test.sv */
/*
 Self-checking bench for the beam teach sequencer: APB register tasks and teach line pulses.
 Assumes the sequencer is built with short pulse limits of 21 and 80 cycles.
*/
`timescale 1ns/1ps
`include "bts_cfg.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module beam_teach_sequencer_test;
   import bts_pkg::*;
   logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, line_two = 0, go = 0, sink = 0;
   logic line_one, busy, pready, pslverr, reserve_adjust, nv_store, err;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd, blocked = '0, corr = '1, beam_deact;
   logic [7:0] fr = 8'h90, lr = 8'h41, interrupted_beam_count;
   logic [1:0] io_state;
   logic [15:0] width = '0;
   bts_disp_t disp;
   int n_mismatch = 0, cmp_count = 0, n_adj = 0, n_nv = 0, n_wt = 0, a0, v0, w0;
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      if (reserve_adjust === 1'b1) n_adj++;
      if (nv_store === 1'b1) n_nv++;
      if (disp.waiting === 1'b1) n_wt++;
   end
   bts_teach_ctl u_ctl (.clk(clk), .sink(sink), .go(go), .width(width), .line(line_one), .busy(busy));
   bts_sequencer #(.PULSE_MIN_CYC(21), .PULSE_MAX_CYC(80)) u_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .config_io_line_one(line_one), .config_io_line_two(line_two),
      .beam_blocked(blocked), .beam_in_corridor(corr), .first_beam_raw(fr), .last_beam_raw(lr),
      .reserve_adjust(reserve_adjust), .nv_store(nv_store), .disp(disp),
      .interrupted_beam_count(interrupted_beam_count), .io_state(io_state), .beam_deact(beam_deact));
   task close_out;
      if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1;
      i = 0;
      do begin @(posedge clk); i++; end while (pready !== 1'b1 && i < 16);
      if (pready !== 1'b1) begin n_mismatch++; close_out; end
      rd = prdata;
      err = pslverr;
      psel <= 0; penable <= 0;
   endtask
   // Walk of a teach is fixed at three cycles after the command write, so eight leaves margin without hiding a lost pulse.
   task teach_cmd(input int adj, input int nv, input logic [7:0] bar);
      a0 = n_adj; v0 = n_nv; w0 = n_wt;
      apb(1, `BTS_OFF_CMD, 32'h1);
      repeat (8) @(posedge clk);
      `CHK("adjust", adj, n_adj - a0)
      `CHK("store", nv, n_nv - v0)
      `CHK("waiting", 2, n_wt - w0)
      `CHK("bar_first", bar, disp.first_beam_level)
      `CHK("bar_last", bar, disp.last_beam_level)
   endtask
   task pulse(input logic [15:0] w, input int adj);
      int i;
      a0 = n_adj;
      @(posedge clk);
      width <= w; go <= 1;
      @(posedge clk);
      go <= 0;
      @(negedge clk);
      i = 0;
      while (busy === 1'b1 && i < 200) begin @(posedge clk); i++; end
      if (busy === 1'b1) begin n_mismatch++; close_out; end
      repeat (10) @(posedge clk);
      `CHK("line_teach", adj, n_adj - a0)
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1;
      apb(0, `BTS_OFF_CTRL, 0);
      `CHK("ctrl", 32'h2, rd)
      `CHK("align", 1'b0, disp.align_view)
      apb(0, 12'h020, 0);
      `CHK("unmapped", 1'b1, err)
      apb(1, `BTS_OFF_CTRL, 32'h3);
      repeat (3) @(posedge clk);
      `CHK("first", 8'h90, disp.first_beam_level)
      `CHK("last", 8'h41, disp.last_beam_level)
      lr <= 8'h90;
      apb(1, `BTS_OFF_CTRL, 32'h2);
      blocked <= 32'h107; line_two <= 1;
      repeat (4) @(posedge clk);
      `CHK("count", 8'h4, interrupted_beam_count)
      `CHK("io", 2'b10, io_state)
      teach_cmd(0, 0, 8'h00);
      blocked <= '0; corr <= 32'hffff_fffe;
      teach_cmd(0, 0, 8'h00);
      corr <= '1;
      apb(1, `BTS_OFF_CTRL, 32'h3);
      teach_cmd(1, 1, 8'hff);
      `CHK("align_back", 1'b1, disp.align_view)
      fr <= 8'h7f;
      teach_cmd(0, 0, 8'h00);
      fr <= 8'h90;
      apb(1, `BTS_OFF_CTRL, 32'h10);
      teach_cmd(1, 0, 8'hff);
      `CHK("proc_back", 1'b0, disp.align_view)
      apb(1, `BTS_OFF_BLANK, 32'h7);
      apb(0, `BTS_OFF_BLANK, 0);
      `CHK("areas", 32'h4, rd)
      blocked <= 32'h20;
      teach_cmd(1, 0, 8'hff);
      `CHK("deact", 32'h70, beam_deact)
      apb(0, `BTS_OFF_DEACT, 0);
      `CHK("deact_reg", 32'h70, rd)
      `CHK("count_blank", 8'h0, interrupted_beam_count)
      pulse(20, 0);
      pulse(21, 1);
      pulse(79, 1);
      pulse(80, 0);
      apb(1, `BTS_OFF_CTRL, 32'h18);
      sink <= 1;
      repeat (30) @(posedge clk);
      pulse(40, 1);
      // A changed scan mode calls for a new teach; this restart stands for it.
      sink <= 0; blocked <= '0; rst_n <= 0;
      repeat (8) @(posedge clk);
      rst_n <= 1;
      a0 = n_adj; v0 = n_nv;
      apb(1, `BTS_OFF_CTRL, 32'h6);
      repeat (8) @(posedge clk);
      `CHK("pwrup_adjust", 1, n_adj - a0)
      `CHK("pwrup_store", 1, n_nv - v0)
      `CHK("pwrup_bar", 8'hff, disp.first_beam_level)
      close_out;
   end
endmodule
